// >>> core/seb_pkg.sv
`default_nettype none
package seb_pkg;
  // core clock and millisecond tick
  localparam int SEB_CLK_PERIOD_NS = 20;
  localparam int SEB_MS_NS         = 1_000_000;
  localparam int SEB_MS_CYCLES     = (SEB_MS_NS + SEB_CLK_PERIOD_NS - 1) / SEB_CLK_PERIOD_NS;

  // power-up interval during which servo enable is ignored, in ms
  localparam logic [15:0] SEB_POWERUP_MS    = 16'h0064;
  // speed treated as stopped, in r/min
  localparam logic [15:0] SEB_LOW_SPEED_RPM = 16'h001e;

  // register byte addresses
  localparam logic [7:0] SEB_ADDR_MOVE_DLY = 8'h00;
  localparam logic [7:0] SEB_ADDR_STOP_DLY = 8'h04;
  localparam logic [7:0] SEB_ADDR_SEQ      = 8'h08;
  localparam logic [7:0] SEB_ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] SEB_ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] SEB_ADDR_IRQ_MASK = 8'h14;

  // reset values
  localparam logic [7:0] SEB_MOVE_DLY_RST = 8'h32;
  localparam logic [7:0] SEB_STOP_DLY_RST = 8'h0a;
  localparam logic [5:0] SEB_SEQ_RST      = 6'h00;
  localparam logic [4:0] SEB_IRQ_MASK_RST = 5'h00;

  // sequence register: two bits per trigger, 1 = dynamic brake, 0 = free run
  localparam int SEB_SEQ_W         = 6;
  localparam int SEB_SEQ_SOFF_LSB  = 0;
  localparam int SEB_SEQ_ALARM_LSB = 2;
  localparam int SEB_SEQ_OT_LSB    = 4;
  localparam int SEB_SEQ_DECEL     = 0;
  localparam int SEB_SEQ_STOP      = 1;

  // sticky event bits
  localparam int SEB_IRQ_W     = 5;
  localparam int SEB_IRQ_ALARM = 0;
  localparam int SEB_IRQ_SOFF  = 1;
  localparam int SEB_IRQ_OT    = 2;
  localparam int SEB_IRQ_BRAKE = 3;
  localparam int SEB_IRQ_REFUS = 4;

  typedef enum logic [2:0] {ST_POWERUP, ST_OFF, ST_ON, ST_HOLD, ST_DECEL, ST_FAULT} seb_state_e;
endpackage
`default_nettype wire

// >>> core/seb_sync.sv
`default_nettype none
module seb_sync #(
  parameter int W = 4
) (
  input  wire logic         i_core_clk, // core clock
  input  wire logic         i_rst,      // synchronous reset
  input  wire logic [W-1:0] i_async,    // pin levels
  output logic      [W-1:0] o_sync      // filtered levels
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  wire  [W-1:0] agree = ~(ff2 ^ ff3);

  // a change is taken only once the second and third stages agree
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ff1    <= '0;
      ff2    <= '0;
      ff3    <= '0;
      o_sync <= '0;
    end
    else
    begin
      ff1    <= i_async;
      ff2    <= ff1;
      ff3    <= ff2;
      o_sync <= (agree & ff3) | (~agree & o_sync);
    end
  end
endmodule
`default_nettype wire

// >>> core/seb_ms_timer.sv
`default_nettype none
module seb_ms_timer #(
  parameter int MS_CYCLES = 50000
) (
  input  wire logic        i_core_clk, // core clock
  input  wire logic        i_rst,      // synchronous reset
  input  wire logic        i_start,    // load and start
  input  wire logic [15:0] i_ms,       // interval in ms
  output logic             o_done      // interval elapsed, holds until next start
);
  localparam logic [15:0] PRE_LAST = 16'(MS_CYCLES - 1);
  logic [15:0] pre;
  logic [15:0] cnt;
  logic        run;

  assign o_done = run && (cnt == 16'h0000);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pre <= 16'h0000;
      cnt <= 16'h0000;
      run <= 1'b0;
    end
    else if (i_start)
    begin
      pre <= 16'h0000;
      cnt <= i_ms;
      run <= 1'b1;
    end
    else if (run && cnt != 16'h0000)
    begin
      if (pre == PRE_LAST)
      begin
        pre <= 16'h0000;
        cnt <= cnt - 16'h0001;
      end
      else
      begin
        pre <= pre + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/seb_sequencer.sv
// How it works
// - ignore servo enable during power-up interval
// - alarm: release brake output after shorter delay
// - servo-off moving: same shorter brake delay
// - servo-off stopped: stopped delay before de-energise
// - enable accepted only below low speed
// - enable during deceleration held until stopped
// - brake output high means brake released
// - dynamic brake on servo-off, alarm, overtravel
// - per-trigger parameter picks brake or free-run
// - dynamic brake always on without main power
`default_nettype none
module seb_sequencer
  import seb_pkg::*;
#(
  parameter int MS_CYCLES = SEB_MS_CYCLES
) (
  input  wire logic        i_core_clk,             // 50 MHz core clock
  input  wire logic        i_rst,                  // synchronous reset, high
  input  wire logic        i_servo_enable_input,   // servo enable pin
  input  wire logic        i_cw_travel_inhibit,    // cw overtravel pin
  input  wire logic        i_ccw_travel_inhibit,   // ccw overtravel pin
  input  wire logic        i_main_power_on,        // main power present pin
  input  wire logic        i_alarm,                // protective function tripped
  input  wire logic [15:0] i_speed_rpm,            // measured speed magnitude
  input  wire logic [7:0]  i_addr,                 // register byte address
  input  wire logic [31:0] i_wr_data,              // register write data
  input  wire logic        i_wr,                   // write strobe
  input  wire logic        i_rd,                   // read strobe
  output logic      [31:0] o_rd_data,              // read data, cycle after strobe
  output logic             o_brake_release_output, // high frees the shaft
  output logic             o_dynamic_brake,        // high shorts the windings
  output logic             o_motor_energise,       // power stage enabled
  output logic             o_irq                   // level interrupt
);
  seb_state_e state;
  seb_state_e next_state;

  logic [7:0]           moving_brake_delay_param;
  logic [7:0]           stopped_brake_delay_param;
  logic [SEB_SEQ_W-1:0] seq;
  logic [SEB_IRQ_W-1:0] irq_stat;
  logic [SEB_IRQ_W-1:0] irq_mask;
  logic                 first;
  logic                 ot_prev;
  logic                 en_prev;
  logic [3:0]           pins;
  logic [15:0]          tmr_ms;
  logic                 tmr_done;
  logic                 next_release;
  logic                 next_db;
  logic                 next_energise;
  logic [31:0]          rd_mux;

  wire [1:0] servo_off_sequence_param      = seq[SEB_SEQ_SOFF_LSB +: 2];
  wire [1:0] alarm_stop_sequence_param     = seq[SEB_SEQ_ALARM_LSB +: 2];
  wire [1:0] overtravel_stop_sequence_param = seq[SEB_SEQ_OT_LSB +: 2];

  // pin inputs cross into the core clock
  seb_sync #(
    .W (4)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_main_power_on, i_ccw_travel_inhibit, i_cw_travel_inhibit,
                  i_servo_enable_input}),
    .o_sync     (pins)
  );

  wire en_sync   = pins[0];
  wire ot_active = pins[1] | pins[2];
  wire power_ok  = pins[3];
  wire speed_low = i_speed_rpm < SEB_LOW_SPEED_RPM;

  // picks brake or free-run for one trigger from its two-bit selection
  function automatic logic db_select(input logic [1:0] sel, input logic stopped);
    db_select = stopped ? sel[SEB_SEQ_STOP] : sel[SEB_SEQ_DECEL];
  endfunction

  // ---------------- sequencing ----------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POWERUP:
      begin
        if (tmr_done)
          next_state = ST_OFF;
      end
      ST_OFF:
      begin
        if (en_sync && speed_low && power_ok && !i_alarm)
          next_state = ST_ON;
      end
      ST_ON:
      begin
        if (i_alarm)
          next_state = ST_FAULT;
        else if (!en_sync || !power_ok)
          next_state = speed_low ? ST_HOLD : ST_DECEL;
      end
      ST_HOLD:
      begin
        if (i_alarm)
          next_state = ST_FAULT;
        else if (tmr_done)
          next_state = ST_OFF;
      end
      ST_DECEL:
      begin
        if (i_alarm)
          next_state = ST_FAULT;
        else if (speed_low)
          next_state = ST_OFF;
      end
      ST_FAULT:
      begin
        if (!i_alarm && speed_low)
          next_state = ST_OFF;
      end
    endcase
  end

  // interval for the state being entered
  always_comb
  begin
    unique case (next_state)
      ST_POWERUP: tmr_ms = SEB_POWERUP_MS;
      ST_HOLD:    tmr_ms = {8'h00, stopped_brake_delay_param};
      ST_DECEL:   tmr_ms = {8'h00, moving_brake_delay_param};
      ST_FAULT:   tmr_ms = {8'h00, moving_brake_delay_param};
      default:    tmr_ms = 16'h0000;
    endcase
  end

  wire tmr_start = first || (next_state != state);

  seb_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (tmr_start),
    .i_ms       (tmr_ms),
    .o_done     (tmr_done)
  );

  // brake held released while coasting only until the shorter of delay or low speed;
  // on the entry edge the timer still shows the old interval, so only the source counts
  wire coast_release = !speed_low &&
                       ((state == ST_ON) || (state == next_state && !tmr_done));

  always_comb
  begin
    unique case (next_state)
      ST_ON:    next_release = 1'b1;
      ST_DECEL: next_release = o_brake_release_output && coast_release;
      ST_FAULT: next_release = o_brake_release_output && coast_release;
      default:  next_release = 1'b0;
    endcase
  end

  // overtravel frees the stage so the selected stop method can act
  assign next_energise = (next_state == ST_HOLD) ||
                         (next_state == ST_ON && !ot_active);

  always_comb
  begin
    if (!power_ok)
      next_db = 1'b1;
    else
    begin
      unique case (next_state)
        ST_ON:    next_db = ot_active &&
                            db_select(overtravel_stop_sequence_param, speed_low);
        ST_HOLD:  next_db = 1'b0;
        ST_FAULT: next_db = db_select(alarm_stop_sequence_param, speed_low);
        default:  next_db = db_select(servo_off_sequence_param, speed_low);
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state                  <= ST_POWERUP;
      first                  <= 1'b1;
      o_brake_release_output <= 1'b0;
      o_dynamic_brake        <= 1'b1;
      o_motor_energise       <= 1'b0;
    end
    else
    begin
      state                  <= next_state;
      first                  <= 1'b0;
      o_brake_release_output <= next_release;
      o_dynamic_brake        <= next_db;
      o_motor_energise       <= next_energise;
    end
  end

  // ---------------- registers and events ----------------
  wire wr_move  = i_wr && (i_addr == SEB_ADDR_MOVE_DLY);
  wire wr_stop  = i_wr && (i_addr == SEB_ADDR_STOP_DLY);
  wire wr_seq   = i_wr && (i_addr == SEB_ADDR_SEQ);
  wire wr_mask  = i_wr && (i_addr == SEB_ADDR_IRQ_MASK);
  wire rd_istat = i_rd && (i_addr == SEB_ADDR_IRQ_STAT);

  wire [SEB_IRQ_W-1:0] ev;
  assign ev[SEB_IRQ_ALARM] = (next_state == ST_FAULT) && (state != ST_FAULT);
  assign ev[SEB_IRQ_SOFF]  = (state == ST_ON) &&
                             (next_state == ST_HOLD || next_state == ST_DECEL);
  assign ev[SEB_IRQ_OT]    = ot_active && !ot_prev;
  assign ev[SEB_IRQ_BRAKE] = o_brake_release_output && !next_release;
  // enable raised while it cannot be taken
  assign ev[SEB_IRQ_REFUS] = en_sync && !en_prev && (next_state != ST_ON);

  wire [SEB_IRQ_W-1:0] clr = rd_istat ? {SEB_IRQ_W{1'b1}} : {SEB_IRQ_W{1'b0}};

  always_comb
  begin
    unique case (i_addr)
      SEB_ADDR_MOVE_DLY: rd_mux = {24'h000000, moving_brake_delay_param};
      SEB_ADDR_STOP_DLY: rd_mux = {24'h000000, stopped_brake_delay_param};
      SEB_ADDR_SEQ:      rd_mux = {26'h0000000, seq};
      SEB_ADDR_STATUS:   rd_mux = {23'h000000, power_ok, en_sync, speed_low,
                                   o_dynamic_brake, o_motor_energise,
                                   o_brake_release_output, state};
      SEB_ADDR_IRQ_STAT: rd_mux = {27'h0000000, irq_stat};
      SEB_ADDR_IRQ_MASK: rd_mux = {27'h0000000, irq_mask};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  assign o_irq = |(irq_stat & irq_mask);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      moving_brake_delay_param  <= SEB_MOVE_DLY_RST;
      stopped_brake_delay_param <= SEB_STOP_DLY_RST;
      seq                       <= SEB_SEQ_RST;
      irq_mask                  <= SEB_IRQ_MASK_RST;
      irq_stat                  <= '0;
      ot_prev                   <= 1'b0;
      en_prev                   <= 1'b0;
      o_rd_data                 <= 32'h00000000;
    end
    else
    begin
      if (wr_move)
        moving_brake_delay_param <= i_wr_data[7:0];
      if (wr_stop)
        stopped_brake_delay_param <= i_wr_data[7:0];
      if (wr_seq)
        seq <= i_wr_data[SEB_SEQ_W-1:0];
      if (wr_mask)
        irq_mask <= i_wr_data[SEB_IRQ_W-1:0];
      // a new event in the clearing cycle survives the clear
      irq_stat  <= (irq_stat & ~clr) | ev;
      ot_prev   <= ot_active;
      en_prev   <= en_sync;
      o_rd_data <= i_rd ? rd_mux : 32'h00000000;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_powerup_ignore;
    (state == ST_POWERUP) |=> !o_motor_energise && !o_brake_release_output;
  endproperty
  a_powerup_ignore: assert property (p_powerup_ignore)
    else $error("servo enabled during power-up interval");

  property p_alarm_brake;
    (state == ST_FAULT && speed_low) |-> ##[1:2] !o_brake_release_output;
  endproperty
  a_alarm_brake: assert property (p_alarm_brake)
    else $error("brake not engaged after alarm at low speed");

  property p_decel_delay;
    (state == ST_DECEL && tmr_done) |=> !o_brake_release_output;
  endproperty
  a_decel_delay: assert property (p_decel_delay)
    else $error("brake release held past moving delay");

  property p_coast_entry;
    (state == ST_ON && next_state == ST_DECEL) |=> o_brake_release_output;
  endproperty
  a_coast_entry: assert property (p_coast_entry)
    else $error("brake engaged at start of coasting");

  property p_hold_seq;
    (state == ST_HOLD && !tmr_done && !i_alarm && $stable(state)) |=>
      o_motor_energise && !o_brake_release_output;
  endproperty
  a_hold_seq: assert property (p_hold_seq)
    else $error("stopped servo-off order wrong");

  property p_low_speed_accept;
    (state == ST_OFF && !speed_low) |=> (state != ST_ON) && !o_motor_energise;
  endproperty
  a_low_speed_accept: assert property (p_low_speed_accept)
    else $error("enable accepted above low speed");

  property p_decel_blocked;
    (state == ST_DECEL && en_sync) |=> !o_motor_energise;
  endproperty
  a_decel_blocked: assert property (p_decel_blocked)
    else $error("enable taken during deceleration");

  property p_release_level;
    o_brake_release_output |-> $past(next_state) inside {ST_ON, ST_DECEL, ST_FAULT};
  endproperty
  a_release_level: assert property (p_release_level)
    else $error("brake released outside run or coast");

  property p_alarm_trip;
    (state == ST_ON && i_alarm) |=> state == ST_FAULT ##1 !o_motor_energise;
  endproperty
  a_alarm_trip: assert property (p_alarm_trip)
    else $error("alarm did not trip sequence");

  property p_soff_select;
    (state == ST_OFF && power_ok && next_state == ST_OFF) |=>
      o_dynamic_brake == db_select($past(servo_off_sequence_param), $past(speed_low));
  endproperty
  a_soff_select: assert property (p_soff_select)
    else $error("dynamic brake ignores servo-off selection");

  property p_power_off_db;
    !power_ok |=> o_dynamic_brake;
  endproperty
  a_power_off_db: assert property (p_power_off_db)
    else $error("dynamic brake off without main power");

  c_servo_on:   cover property (state == ST_OFF ##1 state == ST_ON);
  c_moving_off: cover property (state == ST_ON ##1 state == ST_DECEL);
  c_stop_off:   cover property (state == ST_HOLD ##1 state == ST_OFF);
  c_alarm:      cover property (state == ST_ON ##1 state == ST_FAULT);
endmodule
`default_nettype wire

// >>> verif/seb_host_model.sv
`default_nettype none
module seb_host_model #(
  parameter int HIGH_RPM = 1000, // speed counted as high
  parameter int COOL     = 50    // rest after braking from high speed, shortened
) (
  input  wire logic        i_core_clk,          // core clock
  input  wire logic        i_rst,               // reset
  input  wire logic        i_want_on,           // servo on wanted
  input  wire logic        i_force,             // emergency: ignore stop rule
  input  wire logic [15:0] i_speed_rpm,         // motor speed
  input  wire logic        i_dynamic_brake,     // device brake state
  output logic             o_servo_enable_input // enable pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cool;
  logic db_q;

  initial o_servo_enable_input = 1'b0;

  always @(posedge i_core_clk)
  begin
    db_q <= i_dynamic_brake;
    if (i_rst)
      cool <= 0;
    else if (i_dynamic_brake && !db_q && i_speed_rpm >= HIGH_RPM)
      cool <= COOL;
    else if (cool != 0)
      cool <= cool - 1;
    // toggles only at standstill unless an emergency stop is played
    if (i_force || (i_speed_rpm < 16'h001e && (cool == 0 || !i_want_on)))
      o_servo_enable_input <= i_want_on;
  end
endmodule
`default_nettype wire

// >>> verif/tb_servo_enable_brake_sequencer.sv
`default_nettype none
module tb_servo_enable_brake_sequencer
  import seb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        want_on  = 1'b1;
  logic        force_en = 1'b0;
  logic        cw       = 1'b0;
  logic        ccw      = 1'b0;
  logic        pwr      = 1'b1;
  logic        alarm    = 1'b0;
  logic [15:0] speed    = 16'h0000;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        en_pin;
  logic [31:0] rdata;
  logic        rel;
  logic        db;
  logic        energ;
  logic        irq;
  logic [31:0] v;
  int          n;
  int          d;
  int          miscompares = 0;
  int          cmp_count   = 0;
  logic [7:0]  ra[5] = '{SEB_ADDR_MOVE_DLY, SEB_ADDR_STOP_DLY, SEB_ADDR_SEQ,
                         SEB_ADDR_IRQ_MASK, 8'h18};
  logic [31:0] rv[5] = '{32'(SEB_MOVE_DLY_RST), 32'(SEB_STOP_DLY_RST), 32'h0, 32'h0, 32'h0};

  always #10 core_clk = ~core_clk;

  seb_host_model u_host (
    .i_core_clk(core_clk), .i_rst(rst), .i_want_on(want_on), .i_force(force_en),
    .i_speed_rpm(speed), .i_dynamic_brake(db), .o_servo_enable_input(en_pin)
  );

  seb_sequencer #(.MS_CYCLES(MS)) u_dut (
    .i_core_clk(core_clk), .i_rst(rst), .i_servo_enable_input(en_pin),
    .i_cw_travel_inhibit(cw), .i_ccw_travel_inhibit(ccw), .i_main_power_on(pwr),
    .i_alarm(alarm), .i_speed_rpm(speed), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .o_brake_release_output(rel),
    .o_dynamic_brake(db), .o_motor_energise(energ), .o_irq(irq)
  );

  function automatic logic [31:0] exp_db(input logic [1:0] pair, input int stopped);
    return {31'h0, pair[stopped]};
  endfunction

  function automatic logic [31:0] in_win(input int got, input int ms, input int slack);
    return {31'h0, got >= ms * MS - 3 && got <= ms * MS + slack};
  endfunction

  function automatic logic pick(input int sel);
    return sel == 0 ? energ : sel == 1 ? rel : db;
  endfunction

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // n counts edges until the chosen output reaches val
  task automatic wait_sig(input int sel, input logic val, input int lim);
    n = 0;
    cmp_count++;
    while (pick(sel) !== val && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (pick(sel) !== val)
    begin
      miscompares++;
      $display("MISMATCH %0t output %0d never reached %b", $time, sel, val);
      end_of_test();
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    addr  <= a;
    wdata <= dat;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] dat);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1;
    dat = rdata;
  endtask

  initial
  begin
    void'($urandom(15233));
    repeat (5) @(posedge core_clk);
    #1;
    chk({db, rel, energ, irq}, 32'h8, "reset outputs");
    @(posedge core_clk);
    rst <= 1'b0;
    wr_reg(8'h18, 32'hffff_ffff);
    for (int i = 0; i < 5; i++)
    begin
      rd_reg(ra[i], v);
      chk(v, rv[i], "reset value");
    end
    // enable pin is high all through power-up
    repeat (880) @(posedge core_clk);
    #1;
    chk(energ, 32'h0, "on during power-up");
    rd_reg(SEB_ADDR_STATUS, v);
    chk(v[2:0], 32'(ST_POWERUP), "state");
    wait_sig(0, 1'b1, 300);
    chk({db, rel}, 32'h1, "on outputs");
    @(posedge core_clk);
    want_on <= 1'b0;
    wait_sig(1, 1'b0, 20);
    wait_sig(0, 1'b0, 200);
    chk(in_win(n, SEB_STOP_DLY_RST, 5), 32'h1, "stopped delay");
    d = 8 + $urandom_range(0, 40);
    wr_reg(SEB_ADDR_MOVE_DLY, 32'(d));
    @(posedge core_clk);
    want_on <= 1'b1;
    wait_sig(0, 1'b1, 200);
    @(posedge core_clk);
    speed    <= 16'(1000 + $urandom_range(0, 2000));
    force_en <= 1'b1;
    want_on  <= 1'b0;
    wait_sig(0, 1'b0, 20);
    wait_sig(1, 1'b0, 700);
    chk(in_win(n, d, 5), 32'h1, "moving delay");
    // clears the stale refusal from power-up so the later check means something
    rd_reg(SEB_ADDR_IRQ_STAT, v);
    chk(v[SEB_IRQ_SOFF], 32'h1, "servo-off flag");
    chk(v[SEB_IRQ_BRAKE], 32'h1, "brake flag");
    @(posedge core_clk);
    want_on <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    chk(energ, 32'h0, "on while decelerating");
    rd_reg(SEB_ADDR_IRQ_STAT, v);
    chk(v[SEB_IRQ_REFUS], 32'h1, "refused flag");
    speed <= 16'h001e;
    repeat (20) @(posedge core_clk);
    #1;
    chk(energ, 32'h0, "on at threshold");
    @(posedge core_clk);
    speed <= 16'h001d;
    wait_sig(0, 1'b1, 30);
    wr_reg(SEB_ADDR_IRQ_MASK, 32'h1 << SEB_IRQ_ALARM);
    @(posedge core_clk);
    speed <= 16'd1500;
    alarm <= 1'b1;
    wait_sig(0, 1'b0, 10);
    chk(irq, 32'h1, "irq on alarm");
    repeat (40) @(posedge core_clk);
    #1;
    chk(rel, 32'h1, "release while coasting");
    speed <= 16'd20;
    // release must follow the speed, well before the delay
    wait_sig(1, 1'b0, 20);
    rd_reg(SEB_ADDR_IRQ_STAT, v);
    chk(v[SEB_IRQ_ALARM], 32'h1, "alarm flag");
    chk(irq, 32'h0, "irq after read");
    wr_reg(SEB_ADDR_IRQ_MASK, 32'h0);
    @(posedge core_clk);
    alarm <= 1'b0;
    wait_sig(0, 1'b1, 60);
    for (int t = 0; t < 3; t++)
      for (int p = 0; p < 4; p++)
      begin
        wr_reg(SEB_ADDR_SEQ, 32'(p) << (2 * t));
        @(posedge core_clk);
        speed    <= 16'(100 + $urandom_range(0, 1900));
        force_en <= 1'b1;
        case (t)
          0:       want_on <= 1'b0;
          1:       alarm   <= 1'b1;
          default: {cw, ccw} <= p[0] ? 2'b10 : 2'b01;
        endcase
        repeat (12) @(posedge core_clk);
        #1;
        chk(db, exp_db(2'(p), 0), "brake while moving");
        @(posedge core_clk);
        speed <= 16'h0000;
        repeat (12) @(posedge core_clk);
        #1;
        chk(db, exp_db(2'(p), 1), "brake after stop");
        @(posedge core_clk);
        {want_on, force_en, alarm, cw, ccw} <= 5'b10000;
        wait_sig(0, 1'b1, 300);
      end
    wr_reg(SEB_ADDR_SEQ, 32'h0);
    @(posedge core_clk);
    pwr <= 1'b0;
    // power loss at standstill runs the stopped delay before the stage drops
    repeat (120) @(posedge core_clk);
    #1;
    chk({db, energ}, 32'h2, "power off");
    @(posedge core_clk);
    pwr <= 1'b1;
    wait_sig(0, 1'b1, 300);
    end_of_test();
  end
endmodule
`default_nettype wire
